// [tb_top.sv]
// self-checking bench for the two-phase feedback modulator
`timescale 1ns/1ps
module tb_top;
  import tfp_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, casc_gap;
  logic [31:0] wdata, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp, fb_sel;
  logic comp_1, comp_2, casc_in, casc_out, casc_oe, drv1, drv2, fb_en, casc_en;
  integer seed;
  int failures, checks_done, cyc, t0, t1, per, p, i, te;
  wire [3:0] mon = {casc_in, casc_out, drv2, drv1};

  tfp_modulator dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comparator_1(comp_1), .comparator_2(comp_2), .cascade_in(casc_in),
    .cascade_out(casc_out), .cascade_oe(casc_oe), .first_drive_output(drv1),
    .second_drive_output(drv2));

  tfp_far_side far_u (.aclk(aclk), .drive_1(drv1), .drive_2(drv2), .fb_en(fb_en),
    .fb_sel(fb_sel), .casc_en(casc_en), .casc_gap(casc_gap), .comp_1(comp_1),
    .comp_2(comp_2), .casc_pulse(casc_in));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    failures++;
    end_sim();
  endtask : wr

  task rd_reg(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    failures++;
    end_sim();
  endtask : rd_reg

  // sync events only: sampled 1 ns after the edge
  task wait_edge(input int b, input logic lvl, output int t);
    int k;
    logic pv;
    pv = mon[b];
    for (k = 0; k < 3000; k++) begin
      @(posedge aclk);
      #1;
      if (mon[b] === lvl && pv !== lvl) begin
        t = cyc;
        return;
      end
      pv = mon[b];
    end
    failures++;
    end_sim();
  endtask : wait_edge

  initial begin
    seed = 32'ha174;
    {failures, checks_done, cyc} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fb_en, casc_en} = '0;
    {awaddr, araddr, wdata} = '0;
    fb_sel = 2'b01;
    casc_gap = 8'd12;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd_reg(8'(i * 4));
      check(rd, 32'h0);
      check(32'(resp), 32'(i == 5 ? RESP_SLVERR : RESP_OKAY));
    end
    wr(8'h14, 32'h0);
    check(32'(resp), 32'(RESP_SLVERR));
    wr(CLOCK_OFFSET, 32'h03);
    repeat (20) @(posedge aclk);
    rd_reg(STATUS_OFFSET);
    check(rd, 32'h0);
    rd_reg(CLOCK_OFFSET);
    check(rd, 32'h03);
    fb_en = 1'b1;
    wr(PHASE1_OFFSET, 32'h20);
    for (p = 0; p < 4; p++) begin
      per = 1 + $unsigned($random(seed)) % 8;
      wr(CTRL_OFFSET, 32'h0);
      wr(CLOCK_OFFSET, 32'(p << 5) | 32'(per));
      wr(CTRL_OFFSET, 32'h01);
      wait_edge(0, 1'b1, t0);
      #1 check(32'(drv1), 32'h0);
      wait_edge(0, 1'b1, t1);
      check(32'(t1 - t0), 32'((1 << p) * (per + 1)));
      check(32'(casc_oe), 32'h0);
    end
    wr(CTRL_OFFSET, 32'h11);
    wait_edge(0, 1'b1, t0);
    #0.5 check(32'(drv1), 32'h1);
    #1.5 check(32'(drv1), 32'h0);
    for (i = 0; i < 8; i++) begin
      te = i >> 1;
      wr(CTRL_OFFSET, 32'h0);
      wr(PHASE1_OFFSET, 32'(te << 5));
      fb_sel = i[0] ? 2'b10 : 2'b01;
      wr(CTRL_OFFSET, 32'h01);
      wait_edge(0, 1'b1, t0);
      #1 check(32'(drv1), 32'((2'(te) & fb_sel) == 2'b00));
      if (te == 0) begin
        repeat (200) @(posedge aclk);
        check(32'(drv1), 32'h1);
      end
    end
    wr(CTRL_OFFSET, 32'h0);
    wr(PHASE2_OFFSET, 32'h20);
    fb_sel = 2'b01;
    wr(CTRL_OFFSET, 32'h02);
    wait_edge(1, 1'b1, t0);
    wait_edge(1, 1'b1, t1);
    check(32'(t1 - t0), 32'(8 * (per + 1)));
    check(32'(drv1), 32'h0);
    // both enables set, as complementary use would need; both delays zero
    wr(CTRL_OFFSET, 32'h03);
    wait_edge(1, 1'b1, t0);
    check(32'(drv1), 32'h1);
    wr(CTRL_OFFSET, 32'h0);
    wr(CLOCK_OFFSET, 32'h25);
    wr(CTRL_OFFSET, 32'h0D);
    wait_edge(2, 1'b1, t0);
    check(32'(casc_oe), 32'h1);
    wait_edge(2, 1'b0, t1);
    check(32'(t1 - t0), 32'h2);
    wait_edge(2, 1'b1, t1);
    check(32'(t1 - t0), 32'd12);
    wr(CTRL_OFFSET, 32'h0);
    wr(CLOCK_OFFSET, 32'h0F);
    wr(PHASE1_OFFSET, 32'h20);
    wr(CTRL_OFFSET, 32'h09);
    repeat (40) @(posedge aclk);
    rd_reg(STATUS_OFFSET);
    check(rd, 32'h0);
    casc_en <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(PHASE1_OFFSET, 32'h20 | 32'(3 * i));
      wait_edge(3, 1'b0, t0);
      wait_edge(0, 1'b1, t1);
      if (i == 0) per = t1 - t0;
      else check(32'(t1 - t0 - per), 32'h3);
      wait_edge(0, 1'b1, t0);
      check(32'(t0 - t1), 32'd12);
    end
    end_sim();
  end
endmodule : tb_top

// [tfp_far_side.sv]
// far-side model: power stage feedback comparators and a cascade master
`timescale 1ns/1ps
module tfp_far_side (
  input wire logic aclk,
  input wire logic drive_1,
  input wire logic drive_2,
  input wire logic fb_en,
  input wire logic [1:0] fb_sel,
  input wire logic casc_en,
  input wire logic [7:0] casc_gap,
  output logic comp_1,
  output logic comp_2,
  output logic casc_pulse
);
  logic [7:0] cnt_r;
  wire any_drive = drive_1 | drive_2;

  initial begin
    comp_1 = 1'b0;
    comp_2 = 1'b0;
    casc_pulse = 1'b0;
    cnt_r = 8'h00;
  end

  // current ramps up after the stage switches on, trips the chosen comparator
  // trip lands after the bench's 1 ns sample point so the rise is still seen
  always @(posedge any_drive) begin
    if (fb_en) begin
      #1.5;
      comp_1 = fb_sel[0];
      comp_2 = fb_sel[1];
    end
  end

  // stage off: sensed current collapses
  always @(negedge any_drive) begin
    #1;
    comp_1 = 1'b0;
    comp_2 = 1'b0;
  end

  // master period kept no longer than the slave's period count
  always @(posedge aclk) begin
    cnt_r <= (!casc_en || cnt_r + 8'h01 == casc_gap) ? 8'h00 : cnt_r + 8'h01;
    casc_pulse <= casc_en && cnt_r == 8'h00;
  end
endmodule : tfp_far_side

// [tfp_modulator.sv]
// two-phase feedback modulator with cascade link and register slave
// Functional notes
// R1: the modulator runs whenever either phase enable is set and stops when both are clear.
// R2: software makes the pins of the two phase outputs outputs in the port direction register.
// R3: software sets both phase enables before using complementary mode.
// R4: the modulator clock is the system clock divided by two to the prescale select value.
// R5: as own master or cascade master the counter resets after reaching the period count.
// R6: software programs a nonzero period count, giving at most half the system clock rate.
// R7: as slave the counter is reset by the pulse received on the cascade pin.
// R8: a slave's period count should be at least the master's.
// R9: an enabled phase output goes active when the counter equals its delay count.
// R10: an active phase output stays active until enabled feedback or shutdown ends it.
// R11: feedback ends the active period asynchronously, without clock sampling.
// R12: per phase, termination enables choose which of the two comparators may end it.
// R13: with no termination enabled the phase output stays active for the whole period.
// R14: with blanking on, comparators are ignored for half a clock after the output rises.
// R15: the cascade field selects own master, slave receiving, or master driving resets.
// R16: the counter holds zero while both enables are clear, and in a slave until the first pulse.
// R17: delay zero starts one modulator clock after the cascade pulse falls, each count adds one; a slave acts on it two aclk late, through its synchronizer.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tfp_modulator
  import tfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_1,
  input wire logic comparator_2,
  input wire logic cascade_in,
  output logic cascade_out,
  output logic cascade_oe,
  output logic first_drive_output,
  output logic second_drive_output
);
  logic [5:0] ctrl_r;
  logic [6:0] clock_r;
  logic [6:0] phase_r [2];
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic armed_r;
  logic casc_meta_r;
  logic casc_sync_r;
  logic sync_out_r;
  logic sync_oe_r;
  logic tick;
  logic [1:0] drive;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic aw_held_r;
  logic w_held_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // configuration fields
  wire logic first_output_enable = ctrl_r[FIRST_EN_BIT];
  wire logic second_output_enable = ctrl_r[SECOND_EN_BIT];
  wire logic [1:0] enables = {second_output_enable, first_output_enable};
  wire logic [1:0] blanking_enable = {ctrl_r[BLANK2_BIT], ctrl_r[BLANK1_BIT]};
  wire tfp_casc_type casc_mode = tfp_casc_type'(ctrl_r[CASC_LSB +: 2]);
  wire logic [4:0] period = clock_r[PERIOD_LSB +: 5];
  wire logic [1:0] clock_prescale_select = clock_r[PRESCALE_LSB +: 2];
  wire logic run = |enables; // see R1
  wire logic is_slave = (casc_mode == TFP_SLAVE); // see R15
  wire logic is_master = (casc_mode == TFP_MASTER); // see R15
  wire logic wrap = (cnt_r >= period);
  wire logic [4:0] cnt_inc = (cnt_r == COUNT_MAX) ? COUNT_MAX : cnt_r + 5'h1;

  tfp_prescale u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .sel(clock_prescale_select),
    .tick(tick)
  );

  // counter next value by mode
  always_comb begin
    if (!run) begin
      cnt_nxt = 5'h0; // see R16
    end else if (is_slave) begin
      if (casc_sync_r) begin
        cnt_nxt = 5'h0; // see R7
      end else if (!armed_r) begin
        cnt_nxt = 5'h0; // see R16
      end else begin
        cnt_nxt = cnt_inc;
      end
    end else begin
      cnt_nxt = wrap ? 5'h0 : cnt_r + 5'h1; // see R5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 5'h0;
    end else if (tick || !run) begin
      cnt_r <= cnt_nxt;
    end
  end

  // cascade input crosses from the pin through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      casc_meta_r <= 1'b0;
      casc_sync_r <= 1'b0;
    end else begin
      casc_meta_r <= cascade_in;
      casc_sync_r <= casc_meta_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || !is_slave) begin
      armed_r <= 1'b0;
    end else if (tick && casc_sync_r) begin
      armed_r <= 1'b1; // see R16
    end
  end

  // master pulse covers the last slot, so delay zero rises one slot after its fall
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || !is_master) begin
      sync_out_r <= 1'b0;
    end else if (tick) begin
      sync_out_r <= (cnt_nxt == period); // see R17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_oe_r <= 1'b0;
    end else begin
      sync_oe_r <= is_master; // see R15
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_phase
      wire logic [4:0] output_delay_count = phase_r[gi][DELAY_LSB +: 5];
      wire logic [1:0] comparator_termination_enable =
          {phase_r[gi][TERM2_BIT], phase_r[gi][TERM1_BIT]};
      // slave outputs stay quiet until the first cascade pulse
      wire logic start = tick && (cnt_r == output_delay_count)
          && (!is_slave || armed_r); // see R9 R17
      tfp_phase u_phase (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(enables[gi]),
        .start(start),
        .blank_en(blanking_enable[gi]),
        .term_en(comparator_termination_enable),
        .comp({comparator_2, comparator_1}),
        .drive(drive[gi])
      );
    end
  endgenerate

  assign first_drive_output = drive[0];
  assign second_drive_output = drive[1];
  assign cascade_out = sync_out_r;
  assign cascade_oe = sync_oe_r;

  // register slave: address and data are taken in either order
  wire logic aw_fire = s_axi_awvalid && awready_r;
  wire logic w_fire = s_axi_wvalid && wready_r;
  wire logic do_write = aw_held_r && w_held_r && !bvalid_r;
  wire logic wr_ctrl = (awaddr_r == CTRL_OFFSET);
  wire logic wr_clock = (awaddr_r == CLOCK_OFFSET);
  wire logic wr_ph1 = (awaddr_r == PHASE1_OFFSET);
  wire logic wr_ph2 = (awaddr_r == PHASE2_OFFSET);
  wire logic wr_hit = wr_ctrl || wr_clock || wr_ph1 || wr_ph2 || (awaddr_r == STATUS_OFFSET);
  wire logic ar_fire = s_axi_arvalid && arready_r;
  wire logic [7:0] status_word = {armed_r, drive, cnt_r};
  wire logic rd_hit = (s_axi_araddr == CTRL_OFFSET) || (s_axi_araddr == CLOCK_OFFSET)
      || (s_axi_araddr == PHASE1_OFFSET) || (s_axi_araddr == PHASE2_OFFSET)
      || (s_axi_araddr == STATUS_OFFSET);
  wire logic [31:0] rd_mux =
      (s_axi_araddr == CTRL_OFFSET) ? {26'h0, ctrl_r} :
      (s_axi_araddr == CLOCK_OFFSET) ? {25'h0, clock_r} :
      (s_axi_araddr == PHASE1_OFFSET) ? {25'h0, phase_r[0]} :
      (s_axi_araddr == PHASE2_OFFSET) ? {25'h0, phase_r[1]} :
      (s_axi_araddr == STATUS_OFFSET) ? {24'h0, status_word} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (w_fire) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      awready_r <= !aw_held_r && !aw_fire && !do_write;
      wready_r <= !w_held_r && !w_fire && !do_write;
    end
  end

  // all fields sit in the low byte lane; status is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      clock_r <= CLOCK_RESET;
      phase_r[0] <= PHASE_RESET;
      phase_r[1] <= PHASE_RESET;
    end else if (do_write && wstrb0_r) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[5:0];
      end
      if (wr_clock) begin
        clock_r <= wdata_r[6:0];
      end
      if (wr_ph1) begin
        phase_r[0] <= wdata_r[6:0];
      end
      if (wr_ph2) begin
        phase_r[1] <= wdata_r[6:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_r && !ar_fire;
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  a_idle_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !run |=> cnt_r == 5'h0)
    else $error("counter not held at zero while stopped"); // see R16
  a_master_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !is_slave && tick && cnt_r == period && $stable(ctrl_r) |=> cnt_r == 5'h0)
    else $error("counter did not wrap at the period count"); // see R5
  a_master_count: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !is_slave && tick && cnt_r < period |=> cnt_r == $past(cnt_r) + 5'h1)
    else $error("counter did not advance on tick"); // see R5
  a_slave_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      run && is_slave && tick && casc_sync_r |=> cnt_r == 5'h0 && armed_r)
    else $error("slave counter not reset by cascade pulse"); // see R7
  a_slave_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      is_slave && !armed_r && !casc_sync_r |=> cnt_r == 5'h0)
    else $error("slave counted before first cascade pulse"); // see R16
  a_sync_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      cascade_out |-> cascade_oe && $past(is_master))
    else $error("cascade pulse driven outside master mode"); // see R15
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid)
    else $error("write response missing after both halves"); // AXI4-Lite handshake, decided for this implementation
endmodule : tfp_modulator

// [tfp_phase.sv]
// one phase output: clocked start, asynchronous feedback termination
`timescale 1ns/1ps
module tfp_phase
  import tfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic start,
  input wire logic blank_en,
  input wire logic [1:0] term_en,
  input wire logic [1:0] comp,
  output logic drive
);
  logic drive_r;
  logic tog_pos_r;
  logic tog_neg_r;
  // blank window runs from the setting rising edge to the next falling edge
  wire logic blank_on = tog_pos_r ^ tog_neg_r;
  wire logic fb_raw = |(term_en & comp); // see R12 R13
  // comparator path is not sampled: a glitch on it ends the pulse too
  wire logic kill = fb_raw && !(blank_en && blank_on); // see R14

  assign drive = drive_r;

  always_ff @(posedge aclk or posedge kill) begin
    if (kill) begin
      drive_r <= 1'b0; // see R10 R11
    end else if (!aresetn || !enable) begin
      drive_r <= 1'b0;
    end else if (start) begin
      drive_r <= 1'b1; // see R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_pos_r <= 1'b0;
    end else if (enable && start) begin
      tog_pos_r <= ~tog_pos_r;
    end
  end

  always_ff @(negedge aclk) begin
    if (!aresetn) begin
      tog_neg_r <= 1'b0;
    end else begin
      tog_neg_r <= tog_pos_r;
    end
  end

  a_drive_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable |=> !drive)
    else $error("phase output active while disabled"); // see R1
  a_full_duty: assert property (@(posedge aclk) disable iff (!aresetn)
      enable && drive && term_en == 2'h0 && $stable(enable) |=> drive)
    else $error("phase output ended without feedback"); // see R13
  a_start_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      start && enable && term_en == 2'h0 |=> drive)
    else $error("phase output did not start on match"); // see R9
  a_feedback_ends: assert property (@(posedge aclk) disable iff (!aresetn)
      fb_raw && !blank_en && !start |=> !drive)
    else $error("feedback did not end the phase output"); // see R10
endmodule : tfp_phase

// [tfp_pkg.sv]
// shared constants of the two-phase feedback modulator
package tfp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CLOCK_OFFSET = 8'h04;
  localparam logic [7:0] PHASE1_OFFSET = 8'h08;
  localparam logic [7:0] PHASE2_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  // control register fields
  localparam int FIRST_EN_BIT = 0;
  localparam int SECOND_EN_BIT = 1;
  localparam int CASC_LSB = 2;
  localparam int BLANK1_BIT = 4;
  localparam int BLANK2_BIT = 5;
  // clock register fields
  localparam int PERIOD_LSB = 0;
  localparam int PRESCALE_LSB = 5;
  // phase register fields
  localparam int DELAY_LSB = 0;
  localparam int TERM1_BIT = 5;
  localparam int TERM2_BIT = 6;
  // status register fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_DRIVE_LSB = 5;
  localparam int STAT_ARMED_BIT = 7;
  // values after reset
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [6:0] CLOCK_RESET = 7'h00;
  localparam logic [6:0] PHASE_RESET = 7'h00;
  localparam logic [4:0] COUNT_MAX = 5'h1F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TFP_OWN0 = 2'b00,
    TFP_OWN1 = 2'b01,
    TFP_SLAVE = 2'b10,
    TFP_MASTER = 2'b11
  } tfp_casc_type;
endpackage : tfp_pkg

// [tfp_prescale.sv]
// power-of-two divider producing the modulator clock tick
`timescale 1ns/1ps
module tfp_prescale
  import tfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  wire logic [2:0] div_last = 3'((4'h1 << sel) - 4'h1);

  assign tick = run && (div_r >= div_last); // see R4
  assign div_nxt = (!run || tick) ? 3'h0 : div_r + 3'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // one tick every 2**sel clocks while running
  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && run && sel == 2'h3 && $stable(sel) |=> !tick [*7] ##1 (tick || !run || sel != 2'h3))
    else $error("prescaler tick spacing wrong for divide by eight"); // see R4
endmodule : tfp_prescale
